// [logic/pic_arbiter.sv]
// picks the most urgent eligible source; equal levels go to the lower index
`timescale 1ns/1ns
`default_nettype none

module pic_arbiter (
  input  wire logic [31:0]       elig,
  input  wire logic [31:0][2:0]  lvl,
  output logic                   valid,
  output logic [4:0]             id,
  output logic [2:0]             best
);

  // ==========================================================================
  // strict compare while scanning upward keeps the lowest index on ties
  always_comb begin
    valid = 1'b0;
    id    = 5'h00;
    best  = 3'h7;
    for (int i = 0; i < 32; i++) begin
      if (elig[i] && (!valid || (lvl[i] < best))) begin
        valid = 1'b1;
        id    = 5'(i);
        best  = lvl[i];
      end
    end
  end

endmodule

`default_nettype wire

// [logic/pic_pkg.sv]
// shared constants, types and decode helpers of the priority interrupt controller
package pic_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned NSRC      = 32;
  localparam int unsigned IDW       = 5;
  localparam int unsigned PRIOW     = 8;
  localparam int unsigned LVLW      = 3;
  localparam int unsigned AW        = 8;

  // ==========================================================================
  // register word indices (byte address is four times the index)
  localparam logic [5:0] W_GATE     = 6'h00;
  localparam logic [5:0] W_EN_SET   = 6'h02;
  localparam logic [5:0] W_EN_CLR   = 6'h03;
  localparam logic [5:0] W_PEND_SET = 6'h04;
  localparam logic [5:0] W_PEND_CLR = 6'h05;
  localparam logic [5:0] W_ACTIVE   = 6'h06;
  localparam logic [5:0] W_GROUP    = 6'h07;
  localparam logic [5:0] W_MASK     = 6'h08;
  localparam logic [5:0] W_EN_QSEL  = 6'h09;
  localparam logic [5:0] W_STATUS   = 6'h0a;
  localparam logic [5:0] W_PRIO0    = 6'h20;

  // ==========================================================================
  // field positions and values
  localparam int unsigned GATE_OPEN_BIT   = 0;
  localparam int unsigned GATE_PREV_BIT   = 1;
  localparam int unsigned GROUP_RAW_LSB   = 8;
  localparam int unsigned STAT_ID_LSB     = 8;
  localparam int unsigned STAT_VALID_BIT  = 16;
  localparam logic [2:0]  LVL_FULL        = 3'h3;
  localparam logic [3:0]  RUN_IDLE        = 4'h8;
  localparam logic [2:0]  LVL_MASK_ALL    = 3'h7;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  word;
    logic [31:0] wdata;
    logic [31:0] wmask;
  } pic_bus_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdat;
  } pic_wb_state_t;

  typedef struct packed {
    logic                  gate_open;
    logic                  gate_prev_closed;
    logic [31:0]           enable;
    logic [31:0]           pending;
    logic [31:0]           active;
    logic [31:0][7:0]      prio;
    logic [2:0]            grouping;
    logic [7:0]            mask;
    logic [4:0]            qsel;
    logic [31:0]           src_q;
    logic                  irq_out;
    logic [4:0]            irq_id;
  } pic_state_t;

  // ==========================================================================
  // helpers
  function automatic logic is_mapped(input logic [5:0] word);
    return word[5] || (word == W_GATE) || ((word >= W_EN_SET) && (word <= W_STATUS));
  endfunction

  // bits counted as preemption level; only three are implemented
  function automatic logic [2:0] preempt_bits(input logic [2:0] grouping);
    return (grouping >= LVL_FULL) ? LVL_FULL : grouping;
  endfunction

  // preemption key: level with its subpriority bits cleared
  function automatic logic [2:0] preempt_key(input logic [2:0] lvl, input logic [2:0] grouping);
    logic [2:0] keep;
    keep = LVL_MASK_ALL << (LVL_FULL - preempt_bits(grouping));
    return lvl & keep;
  endfunction

endpackage

// [logic/pic_top.sv]
// priority interrupt controller: sources, priorities, masking and gated processor request
//
// What this block does
// - closed gate withholds request, enables kept
// - opened gate forwards request again, enables kept
// - gate state before last change is readable
// - enable query reads nonzero when source enabled
// - software pend acts like hardware request
// - pending waits for higher active handler
// - only enabled sources are dispatched
// - pend clear discards unserviced request
// - grouping sets preemption versus subpriority bits
// - grouping three to seven behave alike
// - grouping read reports preemption bit count
// - mask blocks levels at or above threshold
// - threshold four passes zero to three
// - mask read returns programmed threshold
// - only upper three priority bits compared
// - smaller value ranks higher, zero most urgent
// - highest ranking simultaneous request served first
// - thirty-two sources, eight levels, individually maskable
// - equal priority ties go to lower index
// - same preemption level chains, never preempts
// - per-source enable independent of peripheral
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module pic_top (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic                   wb_ack_o,
  output logic                   wb_err_o,
  output logic [31:0]            wb_dat_o,
  input  wire logic [31:0]       irq_src,
  output logic                   cpu_irq,
  output logic [4:0]             cpu_irq_id,
  input  wire logic              cpu_ack,
  input  wire logic              cpu_done,
  input  wire logic [4:0]        cpu_done_id
);

  // ==========================================================================
  // state and bus front end
  pic_pkg::pic_state_t s_r;
  pic_pkg::pic_state_t s_nxt;
  pic_pkg::pic_bus_t   bus;
  logic [31:0]         rd_value;

  pic_wb_slave u_wb (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_ack_o (wb_ack_o),
    .wb_err_o (wb_err_o),
    .wb_dat_o (wb_dat_o),
    .rd_value (rd_value),
    .bus      (bus)
  );

  // ==========================================================================
  // per-source level, masking and eligibility
  logic [31:0][2:0] lvl;
  logic [31:0]      masked;
  logic [31:0]      elig;
  logic [2:0]       mask_lvl;

  assign mask_lvl = s_r.mask[7:5];

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_src
      assign lvl[gi]    = s_r.prio[gi][7:5];
      assign masked[gi] = (mask_lvl != 3'h0) && (lvl[gi] >= mask_lvl);
      assign elig[gi]   = s_r.pending[gi] && s_r.enable[gi] && !masked[gi];
    end
  endgenerate

  logic       win_valid;
  logic [4:0] win_id;
  logic [2:0] win_lvl;

  pic_arbiter u_arb (
    .elig  (elig),
    .lvl   (lvl),
    .valid (win_valid),
    .id    (win_id),
    .best  (win_lvl)
  );

  // ==========================================================================
  // running preemption level of active handlers
  logic [3:0] running;
  logic [2:0] win_key;
  logic       win_ok;

  always_comb begin
    running = pic_pkg::RUN_IDLE;
    for (int i = 0; i < 32; i++) begin
      if (s_r.active[i] && ({1'b0, pic_pkg::preempt_key(lvl[i], s_r.grouping)} < running)) begin
        running = {1'b0, pic_pkg::preempt_key(lvl[i], s_r.grouping)};
      end
    end
    win_key = pic_pkg::preempt_key(win_lvl, s_r.grouping);
    // equal preemption level waits for completion and is chained after it
    win_ok  = win_valid && ({1'b0, win_key} < running);
  end

  // ==========================================================================
  // next state
  logic [31:0] set_v;
  logic [31:0] clr_v;
  logic [31:0] wbits;
  logic        take;

  always_comb begin
    s_nxt       = s_r;
    wbits       = bus.wdata & bus.wmask;
    take        = cpu_ack && s_r.irq_out;
    set_v       = irq_src & ~s_r.src_q;
    clr_v       = 32'h0000_0000;
    s_nxt.src_q = irq_src;
    if (bus.wr) begin
      case (bus.word)
        pic_pkg::W_GATE: begin
          if (bus.wmask[0]) begin
            s_nxt.gate_prev_closed = !s_r.gate_open;
            s_nxt.gate_open        = bus.wdata[pic_pkg::GATE_OPEN_BIT];
          end
        end
        pic_pkg::W_EN_SET:   s_nxt.enable = s_r.enable | wbits;
        pic_pkg::W_EN_CLR:   s_nxt.enable = s_r.enable & ~wbits;
        pic_pkg::W_PEND_SET: set_v = set_v | wbits;
        pic_pkg::W_PEND_CLR: clr_v = wbits;
        pic_pkg::W_GROUP: begin
          if (bus.wmask[0]) begin
            s_nxt.grouping = bus.wdata[2:0];
          end
        end
        pic_pkg::W_MASK: begin
          if (bus.wmask[0]) begin
            s_nxt.mask = bus.wdata[7:0];
          end
        end
        pic_pkg::W_EN_QSEL: begin
          if (bus.wmask[0]) begin
            s_nxt.qsel = bus.wdata[4:0];
          end
        end
        default: begin
          if (bus.word[5] && bus.wmask[0]) begin
            s_nxt.prio[bus.word[4:0]] = bus.wdata[7:0];
          end
        end
      endcase
    end
    // a take in the finishing cycle keeps its source active
    if (cpu_done) begin
      s_nxt.active[cpu_done_id] = 1'b0;
    end
    if (take) begin
      clr_v[s_r.irq_id]        = 1'b1;
      s_nxt.active[s_r.irq_id] = 1'b1;
    end
    // a new request in the clearing cycle survives
    s_nxt.pending = (s_r.pending & ~clr_v) | set_v;
    s_nxt.irq_out = s_r.gate_open && win_ok && !take;
    s_nxt.irq_id  = win_id;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // read mux
  always_comb begin
    rd_value = 32'h0000_0000;
    case (bus.word)
      pic_pkg::W_GATE: begin
        rd_value[pic_pkg::GATE_OPEN_BIT] = s_r.gate_open;
        rd_value[pic_pkg::GATE_PREV_BIT] = s_r.gate_prev_closed;
      end
      pic_pkg::W_EN_SET:   rd_value = s_r.enable;
      pic_pkg::W_EN_CLR:   rd_value = s_r.enable;
      pic_pkg::W_PEND_SET: rd_value = s_r.pending;
      pic_pkg::W_PEND_CLR: rd_value = s_r.pending;
      pic_pkg::W_ACTIVE:   rd_value = s_r.active;
      pic_pkg::W_GROUP: begin
        rd_value[2:0] = pic_pkg::preempt_bits(s_r.grouping);
        rd_value[pic_pkg::GROUP_RAW_LSB +: 3] = s_r.grouping;
      end
      pic_pkg::W_MASK:     rd_value[7:0] = s_r.mask;
      pic_pkg::W_EN_QSEL:  rd_value[0] = s_r.enable[s_r.qsel];
      pic_pkg::W_STATUS: begin
        rd_value[0] = s_r.irq_out;
        rd_value[pic_pkg::STAT_ID_LSB +: 5] = s_r.irq_id;
        rd_value[pic_pkg::STAT_VALID_BIT]   = win_valid;
      end
      default: begin
        if (bus.word[5]) begin
          rd_value[7:0] = s_r.prio[bus.word[4:0]];
        end
      end
    endcase
  end

  assign cpu_irq    = s_r.irq_out;
  assign cpu_irq_id = s_r.irq_id;

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic better_exists;
  always_comb begin
    better_exists = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (elig[i] && ((lvl[i] < win_lvl) || ((lvl[i] == win_lvl) && (5'(i) < win_id)))) begin
        better_exists = 1'b1;
      end
    end
  end

  property p_gate_closed;
    !s_r.gate_open |=> !cpu_irq;
  endproperty
  a_gate_closed: assert property (p_gate_closed) else $error("request seen with gate closed");

  property p_gate_open;
    (s_r.gate_open && win_ok && !take) |=> (cpu_irq && (cpu_irq_id == $past(win_id)));
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("request not forwarded");

  property p_gate_prev;
    (bus.wr && (bus.word == pic_pkg::W_GATE) && bus.wmask[0])
      |=> (s_r.gate_prev_closed == !$past(s_r.gate_open)) && ($stable(s_r.enable));
  endproperty
  a_gate_prev: assert property (p_gate_prev) else $error("gate history wrong");

  property p_pend_set;
    (bus.wr && (bus.word == pic_pkg::W_PEND_SET)) |=> ((s_r.pending & $past(wbits)) == $past(wbits));
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("software pend lost");

  property p_enabled_only;
    cpu_irq |-> $past(s_r.enable[win_id]);
  endproperty
  a_enabled_only: assert property (p_enabled_only) else $error("disabled source dispatched");

  property p_pend_clr;
    (bus.wr && (bus.word == pic_pkg::W_PEND_CLR))
      |=> ((s_r.pending & $past(wbits & ~(irq_src & ~s_r.src_q))) == 32'h0000_0000);
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending not discarded");

  property p_mask;
    cpu_irq && ($past(mask_lvl) != 3'h0) |-> ($past(lvl[win_id]) < $past(mask_lvl));
  endproperty
  a_mask: assert property (p_mask) else $error("masked level dispatched");

  property p_group_sat;
    (s_r.grouping >= 3'h3) |-> (win_key == win_lvl);
  endproperty
  a_group_sat: assert property (p_group_sat) else $error("grouping above three differs");

  property p_best;
    win_ok ##1 cpu_irq |-> !$past(better_exists);
  endproperty
  a_best: assert property (p_best) else $error("lower ranking source chosen");

  property p_no_preempt;
    cpu_irq |-> ({1'b0, pic_pkg::preempt_key($past(lvl[win_id]), $past(s_r.grouping))} < $past(running));
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("same level preempted");

  property p_reset;
    disable iff (1'b0) !rstn |=> (s_r.enable == 32'h0 && s_r.pending == 32'h0 && !s_r.gate_open && s_r.mask == 8'h0);
  endproperty
  a_reset: assert property (p_reset) else $error("state not cleared by reset");

  c_dispatch:   cover property (!cpu_irq ##1 cpu_irq ##[1:20] cpu_ack);
  c_preempt:    cover property ((s_r.active != 32'h0) && cpu_irq);
  c_mask_block: cover property (s_r.gate_open && win_valid && (mask_lvl != 3'h0) && (elig != (s_r.pending & s_r.enable)));

endmodule

`default_nettype wire

// [logic/pic_wb_slave.sv]
// classic wishbone slave front end: handshake, decode and registered read data
`timescale 1ns/1ns
`default_nettype none

module pic_wb_slave (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic                   wb_ack_o,
  output logic                   wb_err_o,
  output logic [31:0]            wb_dat_o,
  input  wire logic [31:0]       rd_value,
  output pic_pkg::pic_bus_t      bus
);

  // ==========================================================================
  // state
  pic_pkg::pic_wb_state_t s_r;
  pic_pkg::pic_wb_state_t s_nxt;
  logic                   req_new;
  logic                   mapped;

  always_comb begin
    mapped  = pic_pkg::is_mapped(wb_adr_i[7:2]);
    req_new = wb_cyc_i && wb_stb_i && !s_r.ack && !s_r.err;
    s_nxt     = s_r;
    s_nxt.ack = req_new && mapped;
    s_nxt.err = req_new && !mapped;
    if (req_new) begin
      s_nxt.rdat = (mapped && !wb_we_i) ? rd_value : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // writes land on the edge where the master sees ack
  always_comb begin
    bus.wr    = wb_cyc_i && wb_stb_i && wb_we_i && s_r.ack;
    bus.rd    = req_new && mapped && !wb_we_i;
    bus.word  = wb_adr_i[7:2];
    bus.wdata = wb_dat_i;
    bus.wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  end

  assign wb_ack_o = s_r.ack;
  assign wb_err_o = s_r.err;
  assign wb_dat_o = s_r.rdat;

endmodule

`default_nettype wire

// [sim/pic_cpu_model.sv]
// processor core model that takes the gated request and later finishes its handler
`timescale 1ns/1ns
`default_nettype none

module pic_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       cpu_irq,
  input  wire logic [4:0] cpu_irq_id,
  input  wire logic       take_en,
  input  wire logic [3:0] ack_lag,
  input  wire logic       fin_req,
  output logic            cpu_ack,
  output logic            cpu_done,
  output logic [4:0]      cpu_done_id,
  output logic [4:0]      last_id
);
  // ==========================================================================
  // handler stack: the newest taken source finishes first
  logic [7:0][4:0] stack_r;
  logic [2:0]      depth_r;
  logic [3:0]      wait_r;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cpu_ack     <= 1'b0;
      cpu_done    <= 1'b0;
      cpu_done_id <= 5'h00;
      last_id     <= 5'h00;
      depth_r     <= 3'h0;
      wait_r      <= 4'h0;
    end else begin
      cpu_ack     <= 1'b0;
      cpu_done    <= 1'b0;
      // id line carries no meaning between pulses, so it keeps toggling
      cpu_done_id <= ~cpu_done_id;
      wait_r      <= cpu_irq ? wait_r + 4'h1 : 4'h0;
      if (cpu_irq && take_en && !cpu_ack && wait_r >= ack_lag) begin
        cpu_ack          <= 1'b1;
        last_id          <= cpu_irq_id;
        stack_r[depth_r] <= cpu_irq_id;
        depth_r          <= depth_r + 3'h1;
        wait_r           <= 4'h0;
      end else if (fin_req && depth_r != 3'h0) begin
        cpu_done    <= 1'b1;
        cpu_done_id <= stack_r[depth_r - 3'h1];
        depth_r     <= depth_r - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench of the priority interrupt controller
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic        sys_clk, rstn, wb_cyc, wb_stb, wb_we, wb_ack, wb_err, re;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wd, wb_rd, irq_src, rv;
  logic        cpu_irq, cpu_ack, cpu_done, take_en, fin_req;
  logic [4:0]  cpu_irq_id, cpu_done_id, last_id;
  int          num_errors, tests_run, cycles;

  pic_top DUT (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_ack_o(wb_ack), .wb_err_o(wb_err),
    .wb_dat_o(wb_rd), .irq_src(irq_src), .cpu_irq(cpu_irq), .cpu_irq_id(cpu_irq_id), .cpu_ack(cpu_ack),
    .cpu_done(cpu_done), .cpu_done_id(cpu_done_id));

  pic_cpu_model cpu (.sys_clk(sys_clk), .rstn(rstn), .cpu_irq(cpu_irq), .cpu_irq_id(cpu_irq_id),
    .take_en(take_en), .ack_lag(4'h2), .fin_req(fin_req), .cpu_ack(cpu_ack), .cpu_done(cpu_done),
    .cpu_done_id(cpu_done_id), .last_id(last_id));

  // ==========================================================================
  // clock and hang limit
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  // ==========================================================================
  // access and compare tasks
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] ba(input logic [5:0] w);
    return {w, 2'b00};
  endfunction

  // one classic cycle; read data and error are taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_wd  <= d;
    do begin
      @(posedge sys_clk);
    end while (wb_ack !== 1'b1 && wb_err !== 1'b1);
    rv = wb_rd;
    re = wb_err;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] w, input logic [31:0] d);
    wb(1'b1, ba(w), d);
  endtask

  task automatic rd(input string what, input logic [5:0] w, input logic [31:0] m, input logic [31:0] exp);
    wb(1'b0, ba(w), 32'h0);
    check(what, exp, rv & m);
  endtask

  task automatic irq_is(input logic on, input logic [4:0] id);
    repeat (3) @(posedge sys_clk);
    check("cpu_irq", {31'h0, on}, {31'h0, cpu_irq});
    if (on) check("cpu_irq_id", {27'h0, id}, {27'h0, cpu_irq_id});
  endtask

  function automatic logic [5:0] pw(input int n);
    return pic_pkg::W_PRIO0 + 6'(n);
  endfunction

  // ==========================================================================
  // tests
  initial begin
    {rstn, wb_cyc, wb_stb, wb_we, take_en, fin_req} = '0;
    {wb_adr, wb_wd, irq_src, num_errors, tests_run, cycles} = '0;
    wb_sel = 4'hf;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rd("gate", pic_pkg::W_GATE, 32'h3, 32'h0);
    rd("enable", pic_pkg::W_EN_SET, 32'hffffffff, 32'h0);
    rd("pending", pic_pkg::W_PEND_SET, 32'hffffffff, 32'h0);
    rd("group", pic_pkg::W_GROUP, 32'h707, 32'h0);
    rd("mask", pic_pkg::W_MASK, 32'hff, 32'h0);
    rd("prio31", pw(31), 32'hff, 32'h0);
    wb(1'b0, 8'h2c, 32'h0);
    check("unmapped err", 32'h1, {31'h0, re});
    $display("test reset done");

    wr(pw(3), 32'h0);
    wr(pic_pkg::W_EN_SET, 32'h8);
    @(posedge sys_clk);
    irq_src <= 32'h8;
    irq_is(1'b0, 5'h0);
    wr(pic_pkg::W_GATE, 32'h1);
    rd("gate open", pic_pkg::W_GATE, 32'h3, 32'h3);
    irq_is(1'b1, 5'h3);
    wr(pic_pkg::W_GATE, 32'h0);
    rd("gate closed", pic_pkg::W_GATE, 32'h3, 32'h0);
    irq_is(1'b0, 5'h0);
    rd("enable kept", pic_pkg::W_EN_SET, 32'hffffffff, 32'h8);
    wr(pic_pkg::W_EN_QSEL, 32'h3);
    rd("query on", pic_pkg::W_EN_QSEL, 32'h1, 32'h1);
    wr(pic_pkg::W_EN_QSEL, 32'h4);
    rd("query off", pic_pkg::W_EN_QSEL, 32'h1, 32'h0);
    wr(pic_pkg::W_GATE, 32'h1);
    irq_is(1'b1, 5'h3);
    take_en <= 1'b1;
    repeat (8) @(posedge sys_clk);
    take_en <= 1'b0;
    irq_src <= 32'h0;
    check("taken id", 32'h3, {27'h0, last_id});
    rd("active", pic_pkg::W_ACTIVE, 32'hffffffff, 32'h8);
    fin_req <= 1'b1;
    @(posedge sys_clk);
    fin_req <= 1'b0;
    rd("active done", pic_pkg::W_ACTIVE, 32'hffffffff, 32'h0);
    $display("test gate done");

    wr(pic_pkg::W_PEND_SET, 32'h80);
    rd("soft pend", pic_pkg::W_PEND_SET, 32'hffffffff, 32'h80);
    irq_is(1'b0, 5'h0);
    wr(pic_pkg::W_PEND_CLR, 32'h80);
    wr(pic_pkg::W_EN_SET, 32'h80);
    rd("pend cleared", pic_pkg::W_PEND_SET, 32'hffffffff, 32'h0);
    irq_is(1'b0, 5'h0);
    wr(pic_pkg::W_EN_CLR, 32'h88);
    $display("test pending done");

    wr(pw(10), 32'h40);
    wr(pw(11), 32'h3f);
    wr(pw(12), 32'h20);
    wr(pic_pkg::W_EN_SET, 32'h1c00);
    wr(pic_pkg::W_PEND_SET, 32'h1c00);
    irq_is(1'b1, 5'd11);
    rd("status", pic_pkg::W_STATUS, 32'h11f01, 32'h10b01);
    wr(pic_pkg::W_MASK, 32'h40);
    irq_is(1'b1, 5'd11);
    wr(pic_pkg::W_MASK, 32'h3f);
    irq_is(1'b0, 5'h0);
    rd("mask", pic_pkg::W_MASK, 32'hff, 32'h3f);
    wb_sel <= 4'he;
    wr(pic_pkg::W_MASK, 32'h0);
    wb_sel <= 4'hf;
    rd("mask lane", pic_pkg::W_MASK, 32'hff, 32'h3f);
    wr(pic_pkg::W_PEND_CLR, 32'h1800);
    wr(pw(10), 32'h60);
    wr(pic_pkg::W_MASK, 32'h80);
    irq_is(1'b1, 5'd10);
    wr(pw(10), 32'h80);
    irq_is(1'b0, 5'h0);
    wr(pic_pkg::W_MASK, 32'h0);
    irq_is(1'b1, 5'd10);
    $display("test priority done");

    for (int g = 0; g < 8; g++) begin
      wr(pic_pkg::W_GROUP, 32'(g));
      rd("group", pic_pkg::W_GROUP, 32'h707, {21'h0, 3'(g), 5'h0, (g > 3) ? 3'h3 : 3'(g)});
    end
    wr(pic_pkg::W_GROUP, 32'h3);
    take_en <= 1'b1;
    repeat (8) @(posedge sys_clk);
    take_en <= 1'b0;
    check("taken id", 32'ha, {27'h0, last_id});
    wr(pw(20), 32'ha0);
    wr(pw(21), 32'h60);
    wr(pic_pkg::W_EN_SET, 32'h300000);
    wr(pic_pkg::W_PEND_SET, 32'h100000);
    irq_is(1'b0, 5'h0);
    wr(pic_pkg::W_GROUP, 32'h1);
    irq_is(1'b0, 5'h0);
    wr(pic_pkg::W_PEND_SET, 32'h200000);
    irq_is(1'b1, 5'd21);
    wr(pic_pkg::W_GROUP, 32'h0);
    irq_is(1'b0, 5'h0);
    fin_req <= 1'b1;
    @(posedge sys_clk);
    fin_req <= 1'b0;
    irq_is(1'b1, 5'd21);
    $display("test preemption done");
    complete_run();
  end
endmodule
`default_nettype wire
